/* uart_line_modem_status.sv */
// line status, modem status and handshake pin logic of one uart channel
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "uart_lms_defs.svh"

// Summary of operation
// R1: pair select bit picks RTS/CTS or DTR/DSR
// R2: in loopback pair select drives ring status
// R3: RTS drive bit sets RTS pin level
// R4: DTR drive bit sets DTR pin level
// R5: enabled line interrupt on any fifo error
// R6: fifo error flag while errored entries remain
// R7: transmitter empty when holding and shift empty
// R8: holding empty sets on last load, clears on write
// R9: one break character per break, held until high
// R10: framing flag follows character at read position
// R11: parity flag follows character at fifo top
// R12: overrun sets on full fifo, byte dropped
// R13: data ready while any character is held
// R14: low four modem bits are change flags
// R15: carrier status inverts pin, loopback uses bit3
// R16: ring status inverts pin, loopback uses bit2
// R17: DSR status inverts pin, loopback uses DTR bit
// R18: CTS status inverts pin, loopback uses RTS bit
// R19: CTS high halts transmitter after current character
// R20: DSR high halts transmitter after current character
// R21: carrier change flag raises modem interrupt
// R22: ring change flag only at ringing end
// R23: CTS and DSR change flags on any change
// R24: modem status read clears change flags
// R25: line status read clears sticky overrun, break
module uart_line_modem_status
   import uart_lms_pkg::*;
#(
   parameter int RX_DEPTH = `RX_FIFO_DEPTH
) (
   input  wire logic               core_clk,
   input  wire logic               reset,
   input  wire logic [`ADDR_W-1:0] address,
   input  wire logic               read,
   input  wire logic               write,
   input  wire logic [31:0]        writedata,
   output logic      [31:0]        readdata,
   output logic                    waitrequest,
   input  wire logic               rxCharDone,
   input  wire rx_flags_t          rxCharFlags,
   input  wire logic               rxHoldRead,
   input  wire logic               rxFlowHold,
   input  wire logic               txHoldWrite,
   input  wire logic               txShiftLoad,
   input  wire logic               txLastByte,
   input  wire logic               txShiftEmpty,
   input  wire line_pins_t         pinsIn,
   output logic                    rtsN,
   output logic                    dtrN,
   output logic                    txHalt,
   output logic                    lineStatusIrq,
   output logic                    modemStatusIrq
);
   logic [7:0]  modemCtrl_q;
   logic [3:0]  featCtrl_q;
   logic        respond_q;
   logic        overrun_q;
   logic        breakSeen_q;
   logic        breakHeld_q;
   logic        thrEmpty_q;
   logic [3:0]  status_q;
   logic [3:0]  delta_q;
   logic [31:0] readdata_q;
   line_pins_t  pinsStable;
   rx_flags_t   topFlags;
   rx_flags_t   pushFlags;
   logic        rxPush;
   logic        dataReady;
   logic        anyError;
   logic        overrun;
   logic        accept;
   logic        readLine;
   logic        readModem;
   logic        loopback;
   logic        autoFlow;
   logic        pairDtr;
   logic [3:0]  statusNow;
   logic [3:0]  deltaNow;
   logic [7:0]  lineStatus;
   logic [7:0]  modemStatus;

   // decode helper, shared by read and write paths
   function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // pins pass the three-flop filter before any use
   modem_input_sync #(
      .WIDTH     (5),
      .RESET_VAL (`PINS_RESET)
   ) u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .pinIn    (pinsIn),
      .stable   (pinsStable)
   );

   // bus handshake: one wait cycle, then the answer
   assign accept      = (read || write) && respond_q;
   assign waitrequest = (read || write) && !respond_q;
   assign readdata    = readdata_q;
   assign readLine    = accept && read && hit(address, `OFS_LINE_STATUS);
   assign readModem   = accept && read && hit(address, `OFS_MODEM_STATUS);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         respond_q <= 1'b0;
      end else begin
         respond_q <= (read || write) && !respond_q;
      end
   end

   // control fields
   assign loopback = modemCtrl_q[`MCR_LOOPBACK];
   assign autoFlow = featCtrl_q[`FC_AUTO_FLOW];
   assign pairDtr  = modemCtrl_q[`MCR_PAIR_SEL]; // R1

   // software-written registers; write lands on the accepting edge
   always_ff @(posedge core_clk) begin
      if (reset) begin
         modemCtrl_q <= `MCR_RESET;
         featCtrl_q  <= `FC_RESET;
      end else if (accept && write) begin
         if (hit(address, `OFS_MODEM_CONTROL)) begin
            modemCtrl_q <= writedata[7:0];
         end
         if (hit(address, `OFS_FEATURE_CTRL)) begin
            featCtrl_q <= writedata[3:0];
         end
      end
   end

   // only one break character enters per low period of the line
   assign pushFlags = rxCharFlags;
   assign rxPush    = rxCharDone && !(rxCharFlags.breakInd && breakHeld_q); // R9

   always_ff @(posedge core_clk) begin
      if (reset) begin
         breakHeld_q <= 1'b0;
      end else if (rxPush && rxCharFlags.breakInd) begin
         breakHeld_q <= 1'b1; // R9
      end else if (pinsStable.rxLine) begin
         breakHeld_q <= 1'b0; // R9
      end
   end

   rx_error_tracker #(
      .DEPTH (RX_DEPTH)
   ) u_rxerr (
      .core_clk  (core_clk),
      .reset     (reset),
      .fifoMode  (featCtrl_q[`FC_FIFO_MODE]),
      .push      (rxPush),
      .pushFlags (pushFlags),
      .pop       (rxHoldRead),
      .topFlags  (topFlags),
      .dataReady (dataReady),
      .anyError  (anyError),
      .overrun   (overrun)
   );

   // sticky line indications; a new event beats the read clear
   always_ff @(posedge core_clk) begin
      if (reset) begin
         overrun_q <= 1'b0;
      end else if (overrun) begin
         overrun_q <= 1'b1; // R12
      end else if (readLine) begin
         overrun_q <= 1'b0; // R25
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         breakSeen_q <= 1'b0;
      end else if (rxPush && rxCharFlags.breakInd) begin
         breakSeen_q <= 1'b1; // R9
      end else if (readLine) begin
         breakSeen_q <= 1'b0; // R25
      end
   end

   // holding empty: a write in the same cycle as the last load leaves data behind
   always_ff @(posedge core_clk) begin
      if (reset) begin
         thrEmpty_q <= 1'b1;
      end else if (txHoldWrite) begin
         thrEmpty_q <= 1'b0; // R8
      end else if (txShiftLoad && txLastByte) begin
         thrEmpty_q <= 1'b1; // R8
      end
   end

   // line status image
   always_comb begin
      lineStatus    = 8'h00;
      lineStatus[7] = anyError; // R6
      lineStatus[6] = thrEmpty_q && txShiftEmpty; // R7
      lineStatus[5] = thrEmpty_q; // R8
      lineStatus[4] = (dataReady && topFlags.breakInd) || breakSeen_q; // R9
      lineStatus[3] = dataReady && topFlags.framingErr; // R10
      lineStatus[2] = dataReady && topFlags.parityErr; // R11
      lineStatus[1] = overrun_q; // R12
      lineStatus[0] = dataReady; // R13
   end

   // modem status levels: inverted pins, or the control bits in loopback
   // order inside the nibble: cd, ri, dsr, cts
   always_comb begin
      if (loopback) begin
         statusNow[3] = modemCtrl_q[`MCR_USER_TWO]; // R15
         statusNow[2] = modemCtrl_q[`MCR_PAIR_SEL]; // R2 R16
         statusNow[1] = modemCtrl_q[`MCR_DTR]; // R17
         statusNow[0] = modemCtrl_q[`MCR_RTS]; // R18
      end else begin
         statusNow[3] = !pinsStable.cdN; // R15
         statusNow[2] = !pinsStable.riN; // R16
         statusNow[1] = !pinsStable.dsrN; // R17
         statusNow[0] = !pinsStable.ctsN; // R18
      end
   end

   // change detection; ring counts only as ringing ends
   always_comb begin
      deltaNow    = status_q ^ statusNow; // R14
      deltaNow[2] = status_q[2] && !statusNow[2]; // R22
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         status_q <= 4'h0;
      end else begin
         status_q <= statusNow;
      end
   end

   // per bit: a change in the clearing cycle survives the read
   always_ff @(posedge core_clk) begin
      if (reset) begin
         delta_q <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (deltaNow[i]) begin
               delta_q[i] <= 1'b1; // R14 R21 R23
            end else if (readModem) begin
               delta_q[i] <= 1'b0; // R24
            end
         end
      end
   end

   assign modemStatus = {statusNow, delta_q};

   // read data captured during the wait cycle, shown on the accept edge
   always_ff @(posedge core_clk) begin
      if (reset) begin
         readdata_q <= 32'h0000_0000;
      end else if (read && !respond_q) begin
         readdata_q <= 32'h0000_0000;
         case (address)
            `OFS_MODEM_CONTROL: readdata_q[7:0] <= modemCtrl_q;
            `OFS_LINE_STATUS:   readdata_q[7:0] <= lineStatus;
            `OFS_MODEM_STATUS:  readdata_q[7:0] <= modemStatus;
            `OFS_FEATURE_CTRL:  readdata_q[3:0] <= featCtrl_q;
            default:            readdata_q      <= 32'h0000_0000;
         endcase
      end
   end

   // handshake pins; loopback keeps them idle so the peer sees nothing
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rtsN <= 1'b1;
         dtrN <= 1'b1;
      end else if (loopback) begin
         rtsN <= 1'b1;
         dtrN <= 1'b1;
      end else begin
         if (autoFlow && !pairDtr) begin
            rtsN <= rxFlowHold; // R1 R3
         end else begin
            rtsN <= !modemCtrl_q[`MCR_RTS]; // R3
         end
         if (autoFlow && pairDtr) begin
            dtrN <= rxFlowHold; // R1 R4
         end else begin
            dtrN <= !modemCtrl_q[`MCR_DTR]; // R4
         end
      end
   end

   // transmitter stop request; it finishes the character in flight itself
   always_ff @(posedge core_clk) begin
      if (reset) begin
         txHalt <= 1'b0;
      end else if (!autoFlow || loopback) begin
         txHalt <= 1'b0;
      end else if (pairDtr) begin
         txHalt <= pinsStable.dsrN; // R20
      end else begin
         txHalt <= pinsStable.ctsN; // R19
      end
   end

   // interrupt requests as levels
   always_ff @(posedge core_clk) begin
      if (reset) begin
         lineStatusIrq  <= 1'b0;
         modemStatusIrq <= 1'b0;
      end else begin
         lineStatusIrq  <= featCtrl_q[`FC_LINE_IRQ_EN] && (anyError || overrun_q); // R5
         modemStatusIrq <= featCtrl_q[`FC_MODEM_IRQ_EN] && (delta_q != 4'h0); // R21 R23
      end
   end
endmodule
`default_nettype wire

/* uart_lms_defs.svh */
// offsets, field positions, reset values and widths for the status block
`ifndef UART_LMS_DEFS_SVH
`define UART_LMS_DEFS_SVH
`define ADDR_W            4
`define OFS_MODEM_CONTROL 4'h0
`define OFS_LINE_STATUS   4'h4
`define OFS_MODEM_STATUS  4'h8
`define OFS_FEATURE_CTRL  4'hC
`define MCR_DTR           0
`define MCR_RTS           1
`define MCR_PAIR_SEL      2
`define MCR_USER_TWO      3
`define MCR_LOOPBACK      4
`define FC_AUTO_FLOW      0
`define FC_LINE_IRQ_EN    1
`define FC_MODEM_IRQ_EN   2
`define FC_FIFO_MODE      3
`define MCR_RESET         8'h00
`define FC_RESET          4'h0
`define PINS_RESET        5'h1F
`define RX_FIFO_DEPTH     256
`endif

/* uart_lms_pkg.sv */
// types shared by the line and modem status block
package uart_lms_pkg;
   // per-character receive error marks
   typedef struct packed {
      logic breakInd;
      logic framingErr;
      logic parityErr;
   } rx_flags_t;
   // active-low modem inputs plus the receive line
   typedef struct packed {
      logic rxLine;
      logic cdN;
      logic riN;
      logic dsrN;
      logic ctsN;
   } line_pins_t;
endpackage

/* modem_input_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module modem_input_sync #(
   parameter int          WIDTH     = 5,
   parameter logic [4:0]  RESET_VAL = 5'h1F
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] stable
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;

   // stage one is read only by stage two
   always_ff @(posedge core_clk) begin
      if (reset) begin
         stage1_q <= RESET_VAL[WIDTH-1:0];
         stage2_q <= RESET_VAL[WIDTH-1:0];
         stage3_q <= RESET_VAL[WIDTH-1:0];
      end else begin
         stage1_q <= pinIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   // a level counts only once stages two and three agree
   always_ff @(posedge core_clk) begin
      if (reset) begin
         stable <= RESET_VAL[WIDTH-1:0];
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2_q[i] == stage3_q[i]) begin
               stable[i] <= stage3_q[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

/* rx_error_tracker.sv */
// error marks kept beside each receive fifo entry
`timescale 1ns/1ps
`default_nettype none
`include "uart_lms_defs.svh"
module rx_error_tracker
   import uart_lms_pkg::*;
#(
   parameter int DEPTH = `RX_FIFO_DEPTH,
   parameter int PTR_W = $clog2(DEPTH)
) (
   input  wire logic      core_clk,
   input  wire logic      reset,
   input  wire logic      fifoMode,
   input  wire logic      push,
   input  wire rx_flags_t pushFlags,
   input  wire logic      pop,
   output rx_flags_t      topFlags,
   output logic           dataReady,
   output logic           anyError,
   output logic           overrun
);
   rx_flags_t        marks_q [DEPTH];
   logic [PTR_W-1:0] wrPtr_q;
   logic [PTR_W-1:0] rdPtr_q;
   logic [PTR_W:0]   count_q;
   logic [PTR_W:0]   errCount_q;
   logic             full;
   logic             doPush;
   logic             doPop;

   function automatic logic [PTR_W-1:0] ptrNext(input logic [PTR_W-1:0] p);
      ptrNext = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   function automatic logic hasError(input rx_flags_t f);
      hasError = f.parityErr | f.framingErr | f.breakInd;
   endfunction

   // non-fifo mode holds one character only
   assign full      = fifoMode ? (count_q == (PTR_W+1)'(DEPTH)) : (count_q != '0);
   assign doPop     = pop && (count_q != '0);
   assign doPush    = push && (!full || doPop);
   assign overrun   = push && full && !doPop; // R12
   assign topFlags  = marks_q[rdPtr_q];
   assign dataReady = (count_q != '0); // R13
   assign anyError  = (errCount_q != '0); // R6

   // a refused character leaves stored marks untouched
   always_ff @(posedge core_clk) begin
      if (doPush) begin
         marks_q[wrPtr_q] <= pushFlags; // R12
      end
   end

   // pointers and occupancy
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (doPush) begin
            wrPtr_q <= ptrNext(wrPtr_q);
         end
         if (doPop) begin
            rdPtr_q <= ptrNext(rdPtr_q);
         end
         count_q <= count_q + (PTR_W+1)'(doPush) - (PTR_W+1)'(doPop);
      end
   end

   // running total of erroneous entries still stored
   always_ff @(posedge core_clk) begin
      if (reset) begin
         errCount_q <= '0;
      end else begin
         errCount_q <= errCount_q
                       + (PTR_W+1)'(doPush && hasError(pushFlags))
                       - (PTR_W+1)'(doPop && hasError(topFlags)); // R6
      end
   end
endmodule
`default_nettype wire

/* uart_lms_checker.sv */
// port-level assertions for the line and modem status block
`timescale 1ns/1ps
`default_nettype none
`include "uart_lms_defs.svh"
module uart_lms_checker
   import uart_lms_pkg::*;
#(
   parameter int RX_DEPTH = `RX_FIFO_DEPTH
) (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        rxCharDone,
   input wire logic        rxFlowHold,
   input wire line_pins_t  pinsIn,
   input wire logic        rtsN,
   input wire logic        dtrN,
   input wire logic        txHalt,
   input wire logic        lineStatusIrq,
   input wire logic        modemStatusIrq
);
   logic [3:0] pinQuiet_q;
   logic [3:0] rxQuiet_q;
   logic [3:0] ctlQuiet_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // cycles since a possible cause; saturate so a long quiet spell never wraps
   always_ff @(posedge core_clk) begin
      if (reset || write || $changed(pinsIn)) pinQuiet_q <= 4'h0;
      else if (pinQuiet_q != 4'hF) pinQuiet_q <= pinQuiet_q + 4'h1;
      if (reset || write || rxCharDone) rxQuiet_q <= 4'h0;
      else if (rxQuiet_q != 4'hF) rxQuiet_q <= rxQuiet_q + 4'h1;
      if (reset || write || $changed(rxFlowHold)) ctlQuiet_q <= 4'h0;
      else if (ctlQuiet_q != 4'hF) ctlQuiet_q <= ctlQuiet_q + 4'h1;
   end

   AST_WAIT_ONE: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
      else $error("bus answer not after one wait cycle");
   AST_IDLE_FREE: assert property (!(read || write) |-> !waitrequest)
      else $error("wait raised with no request");
   AST_RD_HOLD: assert property ($changed(readdata) |-> $past(read && waitrequest))
      else $error("read data moved outside a read");
   AST_RST_IDLE: assert property ($fell(reset) |-> rtsN && dtrN && !txHalt
      && !lineStatusIrq && !modemStatusIrq)
      else $error("outputs not idle after reset");
   AST_NO_HALT: assert property ((!pinsIn.ctsN && !pinsIn.dsrN) [*8] |-> !txHalt)
      else $error("transmitter halted with both pins low");
   AST_MODEM_IRQ: assert property ($rose(modemStatusIrq) |-> pinQuiet_q < 4'h8)
      else $error("modem interrupt without a cause");
   AST_LINE_IRQ: assert property ($rose(lineStatusIrq) |-> rxQuiet_q < 4'h6)
      else $error("line interrupt without a cause");
   AST_PIN_CAUSE: assert property ($changed(rtsN) || $changed(dtrN) |-> ctlQuiet_q < 4'h6)
      else $error("handshake output moved without a cause");
endmodule

bind uart_line_modem_status uart_lms_checker #(.RX_DEPTH(RX_DEPTH)) uart_lms_checker_inst (
   .core_clk(core_clk), .reset(reset), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .rxCharDone(rxCharDone), .rxFlowHold(rxFlowHold),
   .pinsIn(pinsIn), .rtsN(rtsN), .dtrN(dtrN), .txHalt(txHalt),
   .lineStatusIrq(lineStatusIrq), .modemStatusIrq(modemStatusIrq));
`default_nettype wire

/* modem_peer_model.sv */
// modem side model driving the handshake pins
`timescale 1ns/1ps
`default_nettype none
module modem_peer_model
   import uart_lms_pkg::*;
(
   input  wire logic       core_clk,
   input  wire line_pins_t wantPins,
   input  wire logic       haltReq,
   input  wire logic       autoOn,
   input  wire logic       pairSel,
   output line_pins_t      pinsOut
);
   line_pins_t pins_q = 5'h1F;
   line_pins_t pinsNext;

   // the chosen halt pin overrides the requested level
   always_comb begin
      pinsNext = wantPins;
      if (autoOn && !pairSel) pinsNext.ctsN = haltReq;
      if (autoOn && pairSel) pinsNext.dsrN = haltReq;
   end

   // pins move just after an edge, one assignment per edge
   always_ff @(posedge core_clk) begin
      pins_q <= pinsNext;
   end
   assign pinsOut = pins_q;
endmodule
`default_nettype wire

/* uart_line_modem_status_tb_top.sv */
// self-checking bench for the line and modem status block
`timescale 1ns/1ps
`default_nettype none
module uart_line_modem_status_tb_top
   import uart_lms_pkg::*;
;
   logic        core_clk, reset, read, write, waitrequest, rxCharDone, rxHoldRead;
   logic        rxFlowHold, txHoldWrite, txShiftLoad, txLastByte, txShiftEmpty;
   logic        rtsN, dtrN, txHalt, lineStatusIrq, modemStatusIrq, haltReq, autoOn, pairSel;
   logic        ovr, brk, holdE, shiftE;
   logic [3:0]  address;
   logic [7:0]  e8;
   logic [31:0] writedata, readdata, q, v;
   rx_flags_t   rxCharFlags, f, fq[$];
   line_pins_t  pinsIn, wantPins, pp;
   int          err_total, n_checks, seed, i;

   uart_line_modem_status #(.RX_DEPTH(4)) uart_line_modem_status_inst (
      .core_clk(core_clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .rxCharDone(rxCharDone), .rxCharFlags(rxCharFlags), .rxHoldRead(rxHoldRead),
      .rxFlowHold(rxFlowHold), .txHoldWrite(txHoldWrite), .txShiftLoad(txShiftLoad),
      .txLastByte(txLastByte), .txShiftEmpty(txShiftEmpty), .pinsIn(pinsIn), .rtsN(rtsN),
      .dtrN(dtrN), .txHalt(txHalt), .lineStatusIrq(lineStatusIrq),
      .modemStatusIrq(modemStatusIrq));
   modem_peer_model modem_peer_model_inst (.core_clk(core_clk), .wantPins(wantPins),
      .haltReq(haltReq), .autoOn(autoOn), .pairSel(pairSel), .pinsOut(pinsIn));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic finish_test();
      $display("mismatches=%0d checks=%0d", err_total, n_checks);
      if (err_total == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // one Avalon access, held until wait is seen low at a rising edge
   // values read right after the edge are the ones the slave sampled there
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      @(posedge core_clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= {24'h0, d};
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) begin
         err_total++;
         finish_test();
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // line status from the bench's own picture of fifo and transmitter
   function automatic logic [7:0] lsr_exp();
      logic      e;
      rx_flags_t t;
      e = 1'b0;
      t = 3'h0;
      foreach (fq[k]) e = e | (|fq[k]);
      if (fq.size() > 0) t = fq[0];
      return {e, holdE & shiftE, holdE, t.breakInd | brk, t.framingErr, t.parityErr, ovr,
              fq.size() > 0};
   endfunction

   initial begin
      seed = 43167;
      {err_total, n_checks} = '0;
      {reset, holdE, shiftE, txShiftEmpty} = 4'hF;
      {read, write, rxCharDone, rxHoldRead, rxFlowHold, txHoldWrite} = 6'h0;
      {txShiftLoad, txLastByte, haltReq, autoOn, pairSel, ovr, brk} = 7'h0;
      address = 4'h0;
      writedata = 32'h0;
      rxCharFlags = 3'h0;
      wantPins = 5'h1F;
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      // reset values, then an unmapped offset
      rd(4'h0, 8'h00);
      rd(4'h4, lsr_exp());
      rd(4'h8, 8'h00);
      rd(4'hC, 8'h00);
      bus(1'b1, 4'h2, 8'hFF);
      rd(4'h2, 8'h00);
      // manual drive of both handshake outputs
      for (i = 0; i < 4; i++) begin
         bus(1'b1, 4'h0, i[7:0]);
         wt(2);
         chk({rtsN, dtrN}, {30'h0, ~i[1], ~i[0]});
         rd(4'h0, i[7:0]);
      end
      // loopback: status follows control bits, pins parked high
      for (i = 0; i < 6; i++) begin
         v = $random(seed);
         bus(1'b1, 4'h0, {4'h1, v[3:0]});
         wt(2);
         chk({rtsN, dtrN}, 32'h3);
         bus(1'b0, 4'h8, 8'h00);
         chk(q[7:4], {v[3], v[2], v[0], v[1]});
      end
      bus(1'b1, 4'h0, 8'h00);
      wt(6);
      bus(1'b0, 4'h8, 8'h00);
      // live pins: levels, change flags, clear on read, modem interrupt
      bus(1'b1, 4'hC, 8'h04);
      pp = 5'h1F;
      for (i = 0; i < 12; i++) begin
         v = $random(seed);
         @(posedge core_clk);
         wantPins <= {1'b1, v[3:0]};
         wt(8);
         e8 = {~v[3:0], v[3] ^ pp.cdN, v[2] & ~pp.riN, v[1] ^ pp.dsrN, v[0] ^ pp.ctsN};
         chk(modemStatusIrq, |e8[3:0]);
         rd(4'h8, e8);
         pp = {1'b1, v[3:0]};
      end
      // automatic flow control on either pin pair
      bus(1'b1, 4'hC, 8'h01);
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         bus(1'b1, 4'h0, {5'h0, v[2], 2'h3});
         @(posedge core_clk);
         pairSel <= v[2];
         autoOn <= 1'b1;
         haltReq <= v[0];
         rxFlowHold <= v[1];
         wantPins <= 5'h10;
         wt(8);
         chk(txHalt, v[0]);
         chk({rtsN, dtrN}, v[2] ? {30'h0, 1'b0, v[1]} : {30'h0, v[1], 1'b0});
      end
      // transmit flags, including write and last load together
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         @(posedge core_clk);
         txHoldWrite <= v[0];
         txShiftLoad <= v[1];
         txLastByte <= v[1];
         txShiftEmpty <= v[2];
         @(posedge core_clk);
         {txHoldWrite, txShiftLoad} <= 2'h0;
         holdE = v[0] ? 1'b0 : (v[1] ? 1'b1 : holdE);
         shiftE = v[2];
         rd(4'h4, lsr_exp());
      end
      // receive marks, overrun on a full fifo, line interrupt
      bus(1'b1, 4'hC, 8'h0A);
      for (i = 0; i < 60; i++) begin
         v = $random(seed);
         f = (v[7:6] == 2'h0 && fq.size() < 4) ? v[4:2] : 3'h0;
         @(posedge core_clk);
         rxCharDone <= !v[1];
         rxHoldRead <= (v[1:0] == 2'h2);
         rxCharFlags <= f;
         if (!v[1] && fq.size() == 4) ovr = 1'b1;
         else if (!v[1]) fq.push_back(f);
         else if (!v[0] && fq.size() > 0) void'(fq.pop_front());
         if (!v[1]) brk = brk | f.breakInd;
         @(posedge core_clk);
         {rxCharDone, rxHoldRead} <= 2'h0;
         wt(3);
         e8 = lsr_exp();
         chk(lineStatusIrq, e8[7] | e8[1]);
         if (v[5]) begin
            rd(4'h4, e8);
            {ovr, brk} = 2'h0;
         end
      end
      // break hold: a second break in one low spell of the line is not stored
      @(posedge core_clk);
      wantPins <= 5'h0F;
      rxHoldRead <= 1'b1;
      repeat (5) @(posedge core_clk);
      rxHoldRead <= 1'b0;
      fq.delete();
      for (i = 0; i < 3; i++) begin
         if (i == 2) begin
            wantPins <= 5'h1F;
            wt(8);
         end
         @(posedge core_clk);
         rxCharDone <= 1'b1;
         rxCharFlags <= 3'h4;
         @(posedge core_clk);
         rxCharDone <= 1'b0;
      end
      repeat (2) fq.push_back(3'h4);
      brk = 1'b1;
      rd(4'h4, lsr_exp());
      {ovr, brk} = 2'h0;
      // pop both; a third stored break would leave data ready set
      @(posedge core_clk);
      rxHoldRead <= 1'b1;
      repeat (2) @(posedge core_clk);
      rxHoldRead <= 1'b0;
      fq.delete();
      rd(4'h4, lsr_exp());
      // non-fifo mode holds one character; the next one overruns
      bus(1'b1, 4'hC, 8'h02);
      repeat (2) begin
         @(posedge core_clk);
         rxCharDone <= 1'b1;
         rxCharFlags <= 3'h0;
         @(posedge core_clk);
         rxCharDone <= 1'b0;
      end
      fq.push_back(3'h0);
      ovr = 1'b1;
      wt(2);
      chk(lineStatusIrq, 32'h1);
      rd(4'h4, lsr_exp());
      finish_test();
   end
endmodule
`default_nettype wire
